// >>> src/spg_pkg.sv
// constants, carriers and decode codes for the sixteen-pin gpio configuration block
// assumes one 20 MHz system clock and a single-cycle register port with no wait states
//
// Overview of operation
// - sixteen pins 15..0, each with enable and direction bit at its own position
// - a pin is general purpose only while its enable bit is one
// - an enabled pin with direction bit zero is an input
// - an enabled pin with direction bit one is an output
// - direction has no effect on a pin whose enable bit is clear
// - enable register resets to 0x00F9: bits 7..3 and 0 set
// - direction register resets to zero, all pins start as inputs
// - enable register sits at 0x01B00000, sixteen read/write bits
// - direction register sits at 0x01B00004, sixteen read/write bits
`default_nettype none

package spg_pkg;

  // pin count and field placement
  localparam int SPG_PINS      = 16;
  localparam int SPG_FIELD_LSB = 0;
  localparam int SPG_FIELD_MSB = 15;

  // register byte addresses
  localparam logic [31:0] SPG_ADDR_EN    = 32'h01B0_0000;
  localparam logic [31:0] SPG_ADDR_DIR   = 32'h01B0_0004;
  localparam logic [31:0] SPG_ADDR_DATA  = 32'h01B0_0008;
  localparam logic [31:0] SPG_ADDR_LEVEL = 32'h01B0_000C;

  // reset values
  localparam logic [15:0] SPG_EN_RST   = 16'h00F9;
  localparam logic [15:0] SPG_DIR_RST  = 16'h0000;
  localparam logic [15:0] SPG_DATA_RST = 16'h0000;
  localparam logic [31:0] SPG_RD_IDLE  = 32'h0000_0000;
  localparam logic [15:0] SPG_RSVD_HI  = 16'h0000;

  // clock rate, for reference by timing users
  localparam int SPG_CLK_PERIOD_NS = 50;

  // one bit per pin
  typedef logic [15:0] spg_pins_t;

  // register port request carried as one bundle
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } spg_bus_req_t;

  // register select after address decode
  typedef enum logic [2:0] {
    SPG_SEL_NONE,
    SPG_SEL_EN,
    SPG_SEL_DIR,
    SPG_SEL_DATA,
    SPG_SEL_LEVEL
  } spg_sel_t;

endpackage

`default_nettype wire

// >>> src/spg_pin_cell.sv
// one pad cell: input synchroniser and registered drive for a single pin
// assumes the pad level is asynchronous to clk_sys and the pad resolves oe itself
`timescale 1ns/1ps
`default_nettype none

module spg_pin_cell (
  input  wire logic clk_sys,   // system clock
  input  wire logic rst,       // async reset, active high
  input  wire logic pad_i,     // raw pad level
  input  wire logic enable,    // pin owned by gpio
  input  wire logic dir_out,   // one selects output
  input  wire logic data,      // value to drive
  output logic      level,     // synchronised pad level
  output logic      pad_o,     // drive value
  output logic      pad_oe     // drive enable
);

  logic meta_q;
  logic sync_q;
  logic oe_d;

  // two flops; first one feeds only the second
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= pad_i;
      sync_q <= meta_q;
    end
  end

  assign level = sync_q;

  // drive only when owned and set as output
  assign oe_d = enable & dir_out;

  // registered so the pad never sees decode glitches
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pad_oe <= 1'b0;
      pad_o  <= 1'b0;
    end else begin
      pad_oe <= oe_d;
      pad_o  <= data & oe_d;
    end
  end

endmodule

`default_nettype wire

// >>> src/spg_gpio.sv
// top of the sixteen-pin gpio configuration block: registers, read port and pin cells
// assumes a single-cycle master on the register port and pads that resolve oe per pin
`timescale 1ns/1ps
`default_nettype none

module spg_gpio (
  input  wire logic                  clk_sys,          // 20 MHz system clock
  input  wire logic                  rst,              // async reset, active high
  input  wire spg_pkg::spg_bus_req_t bus_req,          // address, write data, strobes
  output logic [31:0]                bus_rdata,        // read data, cycle after read
  input  wire spg_pkg::spg_pins_t    general_pins_i,   // pad levels in
  output spg_pkg::spg_pins_t         general_pins_o,   // pad drive values
  output spg_pkg::spg_pins_t         general_pins_oe,  // pad drive enables
  output spg_pkg::spg_pins_t         general_pins_gp   // one where gpio owns the pad
);
  import spg_pkg::*;

  // programmable state
  spg_pins_t pin_function_enable_reg_q;
  spg_pins_t pin_function_enable_reg_d;
  spg_pins_t pin_direction_reg_q;
  spg_pins_t pin_direction_reg_d;
  spg_pins_t pin_out_data_q;
  spg_pins_t pin_out_data_d;

  // decode and pin side
  spg_sel_t  sel;
  spg_pins_t pin_level;
  spg_pins_t pin_status;
  logic      wr_en;
  logic      wr_dir;
  logic      wr_data;
  logic [31:0] rdata_d;

  // full-width address compare; aliases would let stray writes move pins
  always_comb begin
    unique case (bus_req.addr)
      SPG_ADDR_EN:    sel = SPG_SEL_EN;
      SPG_ADDR_DIR:   sel = SPG_SEL_DIR;
      SPG_ADDR_DATA:  sel = SPG_SEL_DATA;
      SPG_ADDR_LEVEL: sel = SPG_SEL_LEVEL;
      default:        sel = SPG_SEL_NONE;
    endcase
  end

  // write strobes per register; the level register takes no writes
  assign wr_en   = bus_req.wr && (sel == SPG_SEL_EN);
  assign wr_dir  = bus_req.wr && (sel == SPG_SEL_DIR);
  assign wr_data = bus_req.wr && (sel == SPG_SEL_DATA);

  // only the low half is stored, upper write bits simply drop
  always_comb begin
    pin_function_enable_reg_d = pin_function_enable_reg_q;
    if (wr_en) begin
      pin_function_enable_reg_d = bus_req.wdata[SPG_FIELD_MSB:SPG_FIELD_LSB];
    end
  end

  always_comb begin
    pin_direction_reg_d = pin_direction_reg_q;
    if (wr_dir) begin
      pin_direction_reg_d = bus_req.wdata[SPG_FIELD_MSB:SPG_FIELD_LSB];
    end
  end

  always_comb begin
    pin_out_data_d = pin_out_data_q;
    if (wr_data) begin
      pin_out_data_d = bus_req.wdata[SPG_FIELD_MSB:SPG_FIELD_LSB];
    end
  end

  // enable register, reset pattern keeps some pads on gpio from power up
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_function_enable_reg_q <= SPG_EN_RST;
    end else begin
      pin_function_enable_reg_q <= pin_function_enable_reg_d;
    end
  end

  // direction register, all inputs after reset so nothing drives the board
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_direction_reg_q <= SPG_DIR_RST;
    end else begin
      pin_direction_reg_q <= pin_direction_reg_d;
    end
  end

  // output data latch
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_out_data_q <= SPG_DATA_RST;
    end else begin
      pin_out_data_q <= pin_out_data_d;
    end
  end

  // one cell per pin, bit position equals pin number
  for (genvar gi = 0; gi < SPG_PINS; gi++) begin : g_pin
    spg_pin_cell u_cell (
      .clk_sys (clk_sys),
      .rst     (rst),
      .pad_i   (general_pins_i[gi]),
      .enable  (pin_function_enable_reg_q[gi]),
      .dir_out (pin_direction_reg_q[gi]),
      .data    (pin_out_data_q[gi]),
      .level   (pin_level[gi]),
      .pad_o   (general_pins_o[gi]),
      .pad_oe  (general_pins_oe[gi])
    );
  end

  // status: inputs show the pad, outputs echo their drive, unowned pins read zero
  assign pin_status = pin_function_enable_reg_q &
                      ((~pin_direction_reg_q & pin_level) |
                       (pin_direction_reg_q & pin_out_data_q));

  // pad ownership flag, registered so the pad mux sees a clean level
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      general_pins_gp <= SPG_EN_RST;
    end else begin
      general_pins_gp <= pin_function_enable_reg_q;
    end
  end

  // read mux; unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_d = SPG_RD_IDLE;
    if (bus_req.rd) begin
      unique case (sel)
        SPG_SEL_EN:    rdata_d = {SPG_RSVD_HI, pin_function_enable_reg_q};
        SPG_SEL_DIR:   rdata_d = {SPG_RSVD_HI, pin_direction_reg_q};
        SPG_SEL_DATA:  rdata_d = {SPG_RSVD_HI, pin_out_data_q};
        SPG_SEL_LEVEL: rdata_d = {SPG_RSVD_HI, pin_status};
        SPG_SEL_NONE:  rdata_d = SPG_RD_IDLE;
      endcase
    end
  end

  // read data stands for exactly one cycle, zero otherwise
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bus_rdata <= SPG_RD_IDLE;
    end else begin
      bus_rdata <= rdata_d;
    end
  end

  // ---- checks ----

  // enable pattern right after reset release
  chk_enable_reset: assert property (
    @(posedge clk_sys) disable iff (rst)
    $past(rst) |-> pin_function_enable_reg_q == SPG_EN_RST
  ) else $error("enable register reset value wrong");

  // all inputs right after reset release
  chk_dir_reset: assert property (
    @(posedge clk_sys) disable iff (rst)
    $past(rst) |-> (pin_direction_reg_q == SPG_DIR_RST) && (general_pins_oe == SPG_DIR_RST)
  ) else $error("direction register not cleared by reset");

  // a write to the enable register shows in the next read
  chk_enable_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.wr && bus_req.addr == SPG_ADDR_EN) ##1 (bus_req.rd && bus_req.addr == SPG_ADDR_EN)
    |=> bus_rdata == {SPG_RSVD_HI, $past(bus_req.wdata[15:0], 2)}
  ) else $error("enable write not read back");

  // a write to the direction register lands one cycle later
  chk_dir_write: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.wr && bus_req.addr == SPG_ADDR_DIR)
    |=> pin_direction_reg_q == $past(bus_req.wdata[15:0])
  ) else $error("direction write lost");

  // upper half of every read is zero
  chk_reserved_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    bus_rdata[31:16] == SPG_RSVD_HI
  ) else $error("reserved bits read nonzero");

  // read data only in the cycle after a read strobe
  chk_read_window: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$past(bus_req.rd) |-> bus_rdata == SPG_RD_IDLE
  ) else $error("read data outside its cycle");

  // drive follows enable and direction with one cycle of pad latency
  chk_drive_follow: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> general_pins_oe == ($past(pin_function_enable_reg_q) & $past(pin_direction_reg_q))
  ) else $error("pad enable does not follow configuration");

  // an enabled input pin never drives
  chk_input_quiet: assert property (
    @(posedge clk_sys) disable iff (rst)
    (general_pins_oe & $past(pin_function_enable_reg_q) & ~$past(pin_direction_reg_q)) == SPG_DIR_RST
  ) else $error("input pin driving");

  // a disabled pin never drives, whatever its direction
  chk_disabled_quiet: assert property (
    @(posedge clk_sys) disable iff (rst)
    (general_pins_oe & ~$past(pin_function_enable_reg_q)) == SPG_DIR_RST
  ) else $error("disabled pin driving");

  // ownership flag tracks enable with one cycle
  chk_owner_flag: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> general_pins_gp == $past(pin_function_enable_reg_q)
  ) else $error("ownership flag stale");

  // pin cell 0 drives its own bit only, with every direction set
  chk_bit_position: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.wr && bus_req.addr == SPG_ADDR_EN && bus_req.wdata[15:0] == 16'h0001 &&
     pin_direction_reg_q == 16'hFFFF && !wr_dir) |=> ##1 general_pins_oe == 16'h0001
  ) else $error("pin bit position wrong");

  // an enable write lands at its own edge
  chk_enable_land: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.wr && bus_req.addr == SPG_ADDR_EN)
    |=> pin_function_enable_reg_q == $past(bus_req.wdata[15:0])
  ) else $error("enable write lost");

  // no enable write, no change; stray strobes must not move pads
  chk_enable_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(bus_req.wr && bus_req.addr == SPG_ADDR_EN)
    |=> $stable(pin_function_enable_reg_q)
  ) else $error("enable register changed without a write");

  // no direction write, no change
  chk_dir_hold: assert property (
    @(posedge clk_sys) disable iff (rst)
    !(bus_req.wr && bus_req.addr == SPG_ADDR_DIR)
    |=> $stable(pin_direction_reg_q)
  ) else $error("direction register changed without a write");

  // enable read returns the stored bits of the strobe cycle
  chk_enable_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.rd && bus_req.addr == SPG_ADDR_EN)
    |=> bus_rdata == {SPG_RSVD_HI, $past(pin_function_enable_reg_q)}
  ) else $error("enable read data wrong");

  // direction read returns the stored bits of the strobe cycle
  chk_dir_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.rd && bus_req.addr == SPG_ADDR_DIR)
    |=> bus_rdata == {SPG_RSVD_HI, $past(pin_direction_reg_q)}
  ) else $error("direction read data wrong");

  // unmapped reads give zero so software never sees stale data
  chk_unmapped_read: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.rd && sel == SPG_SEL_NONE)
    |=> bus_rdata == SPG_RD_IDLE
  ) else $error("unmapped read not zero");

  // pins not owned by gpio read zero in the level register
  chk_level_disabled: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.rd && bus_req.addr == SPG_ADDR_LEVEL)
    |=> (bus_rdata[15:0] & ~$past(pin_function_enable_reg_q)) == 16'h0000
  ) else $error("disabled pin reads nonzero");

  // enabled inputs read the synchronised pad, not the data latch
  chk_level_input: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.rd && bus_req.addr == SPG_ADDR_LEVEL)
    |=> ((bus_rdata[15:0] ^ $past(pin_level)) &
         $past(pin_function_enable_reg_q) & ~$past(pin_direction_reg_q)) == 16'h0000
  ) else $error("enabled input does not read its pad");

  // enabled outputs echo their drive value
  chk_level_output: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.rd && bus_req.addr == SPG_ADDR_LEVEL)
    |=> ((bus_rdata[15:0] ^ $past(pin_out_data_q)) &
         $past(pin_function_enable_reg_q) & $past(pin_direction_reg_q)) == 16'h0000
  ) else $error("enabled output does not echo its drive");

  // drive value follows data only where the pin is an enabled output
  chk_pad_value: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) |-> general_pins_o ==
      ($past(pin_function_enable_reg_q) & $past(pin_direction_reg_q) & $past(pin_out_data_q))
  ) else $error("pad drive value wrong");

  // pad level reaches logic after exactly two flops
  chk_sync_depth: assert property (
    @(posedge clk_sys) disable iff (rst)
    !$past(rst) && !$past(rst, 2)
    |-> pin_level == $past(general_pins_i, 2)
  ) else $error("pad synchroniser depth wrong");

  // data latch takes the low half of a write
  chk_data_land: assert property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.wr && bus_req.addr == SPG_ADDR_DATA)
    |=> pin_out_data_q == $past(bus_req.wdata[15:0])
  ) else $error("data write lost");

  // pads quiet and ownership at its reset pattern right after release
  chk_out_reset: assert property (
    @(posedge clk_sys) disable iff (rst)
    $past(rst) |-> (general_pins_o == 16'h0000) && (general_pins_gp == SPG_EN_RST)
  ) else $error("pad outputs wrong after reset");

  // an undriven pad never carries a stale drive value
  chk_undriven_low: assert property (
    @(posedge clk_sys) disable iff (rst)
    (general_pins_o & ~general_pins_oe) == 16'h0000
  ) else $error("drive value on undriven pad");

  // main scenarios
  cov_enable_write: cover property (
    @(posedge clk_sys) disable iff (rst)
    bus_req.wr && bus_req.addr == SPG_ADDR_EN
  );

  cov_pin_drives: cover property (
    @(posedge clk_sys) disable iff (rst)
    general_pins_oe != SPG_DIR_RST
  );

  cov_level_read: cover property (
    @(posedge clk_sys) disable iff (rst)
    bus_req.rd && bus_req.addr == SPG_ADDR_LEVEL ##1 bus_rdata != SPG_RD_IDLE
  );

  cov_unmapped_read: cover property (
    @(posedge clk_sys) disable iff (rst)
    bus_req.rd && sel == SPG_SEL_NONE
  );

  cov_back_to_back: cover property (
    @(posedge clk_sys) disable iff (rst)
    (bus_req.wr && bus_req.addr == SPG_ADDR_EN) ##1 (bus_req.rd && bus_req.addr == SPG_ADDR_EN)
  );

endmodule

`default_nettype wire

// >>> verification/spg_board_model.sv
// board-side model of the sixteen pads: resolves block drive against board levels
// assumes oe high means the block owns the pad, the board drives the rest
`timescale 1ns/1ps
`default_nettype none

module spg_board_model (
  input  wire logic [15:0] pins_o,   // block drive value
  input  wire logic [15:0] pins_oe,  // block drive enable
  input  wire logic [15:0] ext_lvl,  // board level on released pads
  output logic      [15:0] pins_i    // resolved pad level
);
  // released pads show the board's level, never the block's stale drive
  always_comb pins_i = (pins_oe & pins_o) | (~pins_oe & ext_lvl);
endmodule

`default_nettype wire

// >>> verification/spg_gpio_tb.sv
// self-checking bench for the sixteen-pin gpio block
// assumes a single-cycle register port and a board model on the pads
`timescale 1ns/1ps
`default_nettype none

module spg_gpio_tb;
  import spg_pkg::*;
  logic         clk_sys;    // 20 MHz
  logic         rst;        // active high
  spg_bus_req_t bus_req;    // register port request
  logic [31:0]  bus_rdata;  // read data
  spg_pins_t    pins_i;     // resolved pad level
  spg_pins_t    pins_o;     // drive value
  spg_pins_t    pins_oe;    // drive enable
  spg_pins_t    pins_gp;    // gpio ownership
  spg_pins_t    ext_lvl;    // board level
  int           errors;
  int           cmp_count;

  // half period of 25 ns
  always #25 clk_sys = ~clk_sys;

  spg_gpio u_spg_gpio (
    .clk_sys(clk_sys), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .general_pins_i(pins_i), .general_pins_o(pins_o), .general_pins_oe(pins_oe),
    .general_pins_gp(pins_gp));

  spg_board_model u_spg_board_model (
    .pins_o(pins_o), .pins_oe(pins_oe), .ext_lvl(ext_lvl), .pins_i(pins_i));

  // one compare, counted
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [31:0] addr, input logic [31:0] data);
    @(posedge clk_sys);
    bus_req <= '{addr: addr, wdata: data, wr: 1'h1, rd: 1'h0};
    @(posedge clk_sys);
    bus_req.wr <= 1'h0;
  endtask

  // read data stands only in the cycle after the strobe, so sample just there
  task automatic rd_check(input string what, input logic [31:0] addr, input logic [31:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: addr, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge clk_sys);
    bus_req.rd <= 1'h0;
    #1 check(what, bus_rdata, exp);
  endtask

  // write then read with no gap, as the bus allows
  task automatic wr_rd_check(input string what, input logic [31:0] addr, input logic [31:0] data,
                             input logic [31:0] exp);
    @(posedge clk_sys);
    bus_req <= '{addr: addr, wdata: data, wr: 1'h1, rd: 1'h0};
    @(posedge clk_sys);
    bus_req <= '{addr: addr, wdata: 32'h0, wr: 1'h0, rd: 1'h1};
    @(posedge clk_sys);
    bus_req.rd <= 1'h0;
    #1 check(what, bus_rdata, exp);
  endtask

  // let registered pin outputs and the synchroniser settle
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic test_reset;
    rd_check("en reset", SPG_ADDR_EN, 32'h0000_00F9);
    rd_check("dir reset", SPG_ADDR_DIR, 32'h0000_0000);
    check("gp reset", {16'h0, pins_gp}, 32'h0000_00F9);
    check("oe reset", {16'h0, pins_oe}, 32'h0000_0000);
    $display("test_reset done");
  endtask

  task automatic test_reserved;
    wr_reg(SPG_ADDR_DIR, 32'hAAAA_00FF);
    wr_rd_check("en high bits", SPG_ADDR_EN, 32'hFFFF_0F0F, 32'h0000_0F0F);
    rd_check("dir high bits", SPG_ADDR_DIR, 32'h0000_00FF);
    // unmapped place: write lost, read zero, real registers untouched
    wr_reg(32'h01B0_0010, 32'h0000_FFFF);
    rd_check("unmapped", 32'h01B0_0010, 32'h0000_0000);
    rd_check("en kept", SPG_ADDR_EN, 32'h0000_0F0F);
    $display("test_reserved done");
  endtask

  task automatic test_modes;
    logic [15:0] en;
    logic [15:0] dir;
    logic [15:0] dat;
    en = 16'h0F0F;
    dir = 16'h00FF;
    dat = 16'hA5A5;
    @(posedge clk_sys);
    ext_lvl <= 16'h3C3C;
    wr_reg(SPG_ADDR_DATA, {16'h0, dat});
    settle(4);
    check("oe mix", {16'h0, pins_oe}, {16'h0, en & dir});
    check("o mix", {16'h0, pins_o}, {16'h0, en & dir & dat});
    check("gp mix", {16'h0, pins_gp}, {16'h0, en});
    rd_check("level", SPG_ADDR_LEVEL, 32'h0000_0C05);
    // the level register takes no writes; data reads back as written
    wr_reg(SPG_ADDR_LEVEL, 32'h0000_FFFF);
    rd_check("data", SPG_ADDR_DATA, {16'h0, dat});
    rd_check("dir kept", SPG_ADDR_DIR, 32'h0000_00FF);
    $display("test_modes done");
  endtask

  task automatic test_walk;
    logic [15:0] one;
    for (int i = 0; i < 16; i++) begin
      one = 16'h0001 << i;
      // direction first so the pin never drives the wrong way
      wr_reg(SPG_ADDR_DIR, {16'h0, one});
      wr_reg(SPG_ADDR_EN, {16'h0, one});
      settle(3);
      check("oe walk", {16'h0, pins_oe}, {16'h0, one});
    end
    // clear enable, read back at once: direction alone must not drive
    wr_rd_check("en clear", SPG_ADDR_EN, 32'h0000_0000, 32'h0000_0000);
    settle(3);
    check("oe off", {16'h0, pins_oe}, 32'h0000_0000);
    check("gp off", {16'h0, pins_gp}, 32'h0000_0000);
    // every direction set, one enable: only that pad may drive
    wr_reg(SPG_ADDR_DIR, 32'h0000_FFFF);
    wr_reg(SPG_ADDR_EN, 32'h0000_0001);
    settle(3);
    check("oe bit0", {16'h0, pins_oe}, 32'h0000_0001);
    check("o bit0", {16'h0, pins_o}, 32'h0000_0001);
    $display("test_walk done");
  endtask

  // single exit for both the normal end and the watchdog
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // about 170 cycles expected, so this only cuts a hang
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    print_verdict();
  end

  initial begin
    clk_sys = 1'h0;
    rst = 1'h1;
    bus_req = '0;
    ext_lvl = 16'h0000;
    errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    test_reset();
    test_reserved();
    test_modes();
    test_walk();
    print_verdict();
  end
endmodule

`default_nettype wire
